// ### rtl/pmd_exec.v
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "pmd_consts.vh"
module pmd_exec (
    input  wire        clk_in,
    input  wire        sys_rst_in,
    input  wire        op_valid_in,
    input  wire [1:0]  op_kind_in,
    input  wire [1:0]  par_mode_in,
    input  wire [1:0]  addr_mode_in,
    input  wire [2:0]  src1_reg_in,
    input  wire [2:0]  src2_reg_in,
    input  wire [4:0]  src_reg_in,
    input  wire [4:0]  dst_reg_in,
    input  wire        dst1_sel_in,
    input  wire        dst2_sel_in,
    input  wire [31:0] mem3_data_in,
    input  wire [31:0] mem4_data_in,
    input  wire [23:0] store_addr_in,
    input  wire [15:0] imm_in,
    input  wire [31:0] ext_src_data_in,
    input  wire [31:0] ext_dst_data_in,
    input  wire        saturation_mode_in,
    input  wire        status_wr_in,
    input  wire [6:0]  status_wr_data_in,
    input  wire [2:0]  rd_idx_in,
    output wire [39:0] rd_data_out,
    output wire [6:0]  status_out,
    output wire        done_out,
    output wire        store_valid_out,
    output wire [23:0] store_addr_out,
    output wire [31:0] store_data_out,
    output wire        ext_wb_valid_out,
    output wire [4:0]  ext_wb_idx_out,
    output wire [31:0] ext_wb_data_out
);
    reg  [39:0] rf_q [0:7];
    reg  [39:0] rd_data_q;
    reg  [6:0]  status_q;
    reg  [6:0]  status_d;
    reg         done_q;
    reg         store_valid_q;
    reg         store_valid_d;
    reg  [23:0] store_addr_q;
    reg  [31:0] store_data_q;
    reg  [31:0] store_data_d;
    reg         ext_wb_valid_q;
    reg         ext_wb_valid_d;
    reg  [4:0]  ext_wb_idx_q;
    reg  [31:0] ext_wb_data_q;

    reg         wr1_en;
    reg  [2:0]  wr1_idx;
    reg  [39:0] wr1_data;
    reg         wr2_en;
    reg  [2:0]  wr2_idx;
    reg  [39:0] wr2_data;
    reg  [39:0] mul_a;
    reg  [39:0] mul_b;
    reg  [39:0] sub_a;
    reg  [39:0] sub_b;
    reg         flag_upd;
    reg         nf_uf;
    reg         nf_n;
    reg         nf_z;
    reg         nf_v;
    reg         set_luf;
    reg         set_lv;
    reg  [31:0] isrc;
    reg  [31:0] idst;
    reg  [31:0] ires;

    wire [39:0] mul_y;
    wire        mul_ovf;
    wire        mul_unf;
    wire [39:0] sub_y;
    wire        sub_ovf;
    wire        sub_unf;

    // single-precision memory words widen to extended by padding the fraction
    wire [39:0] m3_ext = {mem3_data_in, `PMD_SP_PAD};
    wire [39:0] m4_ext = {mem4_data_in, `PMD_SP_PAD};
    // registers are read straight from the array: the values that stood at the cycle start
    wire [39:0] r1_val = rf_q[src1_reg_in];
    wire [39:0] r2_val = rf_q[src2_reg_in];
    wire        dst_in_rf = (dst_reg_in < `PMD_NUM_XREGS);
    wire        src_in_rf = (src_reg_in < `PMD_NUM_XREGS);

    wire signed [47:0] iprod = $signed(isrc[`PMD_INT_SGN:0]) * $signed(idst[`PMD_INT_SGN:0]);
    wire        iovf = (iprod[47:32] != {16{iprod[31]}});

    pmd_fmul u_fmul (
        .a_in    (mul_a),
        .b_in    (mul_b),
        .y_out   (mul_y),
        .ovf_out (mul_ovf),
        .unf_out (mul_unf)
    );

    pmd_fsub u_fsub (
        .a_in    (sub_a),
        .b_in    (sub_b),
        .y_out   (sub_y),
        .ovf_out (sub_ovf),
        .unf_out (sub_unf)
    );

    // integer operand selection
    always @* begin
        case (addr_mode_in)
            `PMD_G_REG: begin
                isrc = src_in_rf ? rf_q[src_reg_in[2:0]][31:0] : ext_src_data_in;
            end
            `PMD_G_DIRECT: begin
                isrc = mem3_data_in;
            end
            `PMD_G_INDIRECT: begin
                isrc = mem3_data_in;
            end
            `PMD_G_IMM: begin
                isrc = {{16{imm_in[15]}}, imm_in};
            end
            default: begin
                isrc = 32'h00000000;
            end
        endcase
        idst = dst_in_rf ? rf_q[dst_reg_in[2:0]][31:0] : ext_dst_data_in;
        ires = iprod[31:0];
        // saturation only shapes the integer result; float paths never look at it
        if (saturation_mode_in && iovf)
            ires = iprod[47] ? `PMD_INT_MIN : `PMD_INT_MAX;
    end

    // operand routing and result steering, all from cycle-start values
    always @* begin
        wr1_en         = 1'b0;
        wr1_idx        = 3'h0;
        wr1_data       = `PMD_REG_RST;
        wr2_en         = 1'b0;
        wr2_idx        = 3'h0;
        wr2_data       = `PMD_REG_RST;
        mul_a          = r1_val;
        mul_b          = m3_ext;
        sub_a          = r1_val;
        sub_b          = r2_val;
        flag_upd       = 1'b0;
        nf_uf          = 1'b0;
        nf_n           = 1'b0;
        nf_z           = 1'b0;
        nf_v           = 1'b0;
        set_luf        = 1'b0;
        set_lv         = 1'b0;
        store_valid_d  = 1'b0;
        store_data_d   = 32'h00000000;
        ext_wb_valid_d = 1'b0;
        if (op_valid_in) begin
            case (op_kind_in)
                `PMD_OP_MPYF_STF: begin
                    wr1_en       = 1'b1;
                    wr1_idx      = dst_reg_in[2:0];
                    wr1_data     = mul_y;
                    // store data is the register before this cycle's product lands
                    store_valid_d = 1'b1;
                    store_data_d  = r2_val[39:8];
                    // mem3 was fetched ahead of execute, so the store cannot disturb it
                    flag_upd = 1'b1;
                    nf_uf    = mul_unf;
                    nf_v     = mul_ovf;
                    nf_n     = mul_y[`PMD_SGN_BIT] && (mul_y[`PMD_EXP_MSB:`PMD_EXP_LSB] != `PMD_EXP_ZERO);
                    nf_z     = (mul_y[`PMD_EXP_MSB:`PMD_EXP_LSB] == `PMD_EXP_ZERO);
                    set_luf  = mul_unf;
                    set_lv   = mul_ovf;
                end
                `PMD_OP_MPYF_SUBF: begin
                    case (par_mode_in)
                        `PMD_P_MEM_MEM: begin
                            mul_a = m3_ext;
                            mul_b = m4_ext;
                            sub_a = r1_val;
                            sub_b = r2_val;
                        end
                        `PMD_P_MEM_REG: begin
                            mul_a = m3_ext;
                            mul_b = r1_val;
                            sub_a = m4_ext;
                            sub_b = r2_val;
                        end
                        `PMD_P_REG_REG: begin
                            mul_a = r1_val;
                            mul_b = r2_val;
                            sub_a = m3_ext;
                            sub_b = m4_ext;
                        end
                        default: begin
                            mul_a = m3_ext;
                            mul_b = r1_val;
                            sub_a = r2_val;
                            sub_b = m4_ext;
                        end
                    endcase
                    // both units work on the same snapshot, so a subtract
                    // target seen by the multiply still shows its old value
                    wr1_en   = 1'b1;
                    wr1_idx  = {2'h0, dst1_sel_in};
                    wr1_data = mul_y;
                    wr2_en   = 1'b1;
                    wr2_idx  = {2'h1, dst2_sel_in};
                    wr2_data = sub_y;
                    flag_upd = 1'b1;
                    nf_uf    = mul_unf | sub_unf;
                    nf_v     = mul_ovf | sub_ovf;
                    nf_n     = 1'b0;
                    nf_z     = 1'b0;
                    set_luf  = mul_unf | sub_unf;
                    set_lv   = mul_ovf | sub_ovf;
                end
                `PMD_OP_INTEGER_MULTIPLY: begin
                    wr1_en         = dst_in_rf;
                    wr1_idx        = dst_reg_in[2:0];
                    wr1_data       = {`PMD_INT_TOP, ires};
                    ext_wb_valid_d = !dst_in_rf;
                    flag_upd       = dst_in_rf;
                    nf_uf          = 1'b0;
                    nf_v           = iovf;
                    nf_n           = ires[31];
                    nf_z           = (ires == 32'h00000000);
                    set_lv         = iovf;
                end
                default: begin
                    flag_upd = 1'b0;
                end
            endcase
        end
    end

    // status: software load first, then the operation; a sticky set beats a clear
    always @* begin
        status_d = status_wr_in ? status_wr_data_in : status_q;
        if (flag_upd) begin
            status_d[`PMD_FB_UF]  = nf_uf;
            status_d[`PMD_FB_N]   = nf_n;
            status_d[`PMD_FB_Z]   = nf_z;
            status_d[`PMD_FB_V]   = nf_v;
            status_d[`PMD_FB_LUF] = status_d[`PMD_FB_LUF] | set_luf;
            status_d[`PMD_FB_LV]  = status_d[`PMD_FB_LV] | set_lv;
        end
        // carry is never touched by a multiply
        status_d[`PMD_FB_C] = status_wr_in ? status_wr_data_in[`PMD_FB_C] : status_q[`PMD_FB_C];
    end

    // register file: one write port per parallel half, both land at the cycle end
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_rf
            localparam integer IDX = gi;
            always @(posedge clk_in) begin
                if (sys_rst_in) begin
                    rf_q[gi] <= `PMD_REG_RST;
                end else if (wr1_en && (wr1_idx == IDX[2:0])) begin
                    rf_q[gi] <= wr1_data;
                end else if (wr2_en && (wr2_idx == IDX[2:0])) begin
                    rf_q[gi] <= wr2_data;
                end
            end
        end
    endgenerate

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            status_q       <= `PMD_STATUS_RST;
            rd_data_q      <= `PMD_REG_RST;
            done_q         <= 1'b0;
            store_valid_q  <= 1'b0;
            store_addr_q   <= 24'h000000;
            store_data_q   <= 32'h00000000;
            ext_wb_valid_q <= 1'b0;
            ext_wb_idx_q   <= 5'h00;
            ext_wb_data_q  <= 32'h00000000;
        end else begin
            status_q       <= status_d;
            rd_data_q      <= rf_q[rd_idx_in];
            done_q         <= op_valid_in;
            store_valid_q  <= store_valid_d;
            store_addr_q   <= store_addr_in;
            store_data_q   <= store_data_d;
            ext_wb_valid_q <= ext_wb_valid_d;
            ext_wb_idx_q   <= dst_reg_in;
            ext_wb_data_q  <= ires;
        end
    end

    assign rd_data_out      = rd_data_q;
    assign status_out       = status_q;
    assign done_out         = done_q;
    assign store_valid_out  = store_valid_q;
    assign store_addr_out   = store_addr_q;
    assign store_data_out   = store_data_q;
    assign ext_wb_valid_out = ext_wb_valid_q;
    assign ext_wb_idx_out   = ext_wb_idx_q;
    assign ext_wb_data_out  = ext_wb_data_q;
endmodule // pmd_exec

// ### include/pmd_consts.vh
`ifndef PMD_CONSTS_VH
`define PMD_CONSTS_VH
// operation kinds
`define PMD_OP_MPYF_STF   2'h0
`define PMD_OP_MPYF_SUBF  2'h1
`define PMD_OP_INTEGER_MULTIPLY       2'h2
// parallel operand routing codes
`define PMD_P_MEM_MEM     2'h0
`define PMD_P_MEM_REG     2'h1
`define PMD_P_REG_REG     2'h2
`define PMD_P_MIXED       2'h3
// integer multiply source modes
`define PMD_G_REG         2'h0
`define PMD_G_DIRECT      2'h1
`define PMD_G_INDIRECT    2'h2
`define PMD_G_IMM         2'h3
// extended float layout: exponent, sign, fraction
`define PMD_EXP_MSB       39
`define PMD_EXP_LSB       32
`define PMD_SGN_BIT       31
`define PMD_FRAC_MSB      30
`define PMD_INT_SGN       23
`define PMD_EXP_ZERO      8'h80
`define PMD_EXP_TOP       8'h7f
`define PMD_EXP_MAX       10'h07f
`define PMD_EXP_MIN       10'h381
`define PMD_EXP_ONE       10'h001
`define PMD_FRAC_FULL     31'h7fffffff
`define PMD_SP_PAD        8'h00
`define PMD_INT_TOP       8'h00
`define PMD_ALIGN_LIMIT   9'h020
`define PMD_NUM_XREGS     5'h08
`define PMD_INT_MAX       32'h7fffffff
`define PMD_INT_MIN       32'h80000000
`define PMD_REG_RST       40'h0000000000
`define PMD_STATUS_RST    7'h00
// status bit positions
`define PMD_FB_LUF        6
`define PMD_FB_LV         5
`define PMD_FB_UF         4
`define PMD_FB_N          3
`define PMD_FB_Z          2
`define PMD_FB_V          1
`define PMD_FB_C          0
`endif

// ### rtl/pmd_fmul.v
`timescale 1ns/1ps
`include "pmd_consts.vh"
module pmd_fmul (
    input  wire [39:0] a_in,
    input  wire [39:0] b_in,
    output reg  [39:0] y_out,
    output reg         ovf_out,
    output reg         unf_out
);
    wire [7:0]  ea      = a_in[`PMD_EXP_MSB:`PMD_EXP_LSB];
    wire [7:0]  eb      = b_in[`PMD_EXP_MSB:`PMD_EXP_LSB];
    wire        zero_in = (ea == `PMD_EXP_ZERO) || (eb == `PMD_EXP_ZERO);
    wire        sgn     = a_in[`PMD_SGN_BIT] ^ b_in[`PMD_SGN_BIT];
    wire [31:0] ma      = {1'b1, a_in[`PMD_FRAC_MSB:0]};
    wire [31:0] mb      = {1'b1, b_in[`PMD_FRAC_MSB:0]};
    wire [63:0] prod    = ma * mb;
    wire [9:0]  esum    = {{2{ea[7]}}, ea} + {{2{eb[7]}}, eb};
    reg  [9:0]  en;
    reg  [30:0] fr;

    // both mantissas carry a hidden one, so the product top lies in bit 63 or 62
    always @* begin
        en      = esum;
        fr      = prod[61:31];
        ovf_out = 1'b0;
        unf_out = 1'b0;
        y_out   = {`PMD_EXP_ZERO, 32'h00000000};
        if (prod[63]) begin
            en = esum + `PMD_EXP_ONE;
            fr = prod[62:32];
        end
        if (!zero_in) begin
            if ($signed(en) > $signed(`PMD_EXP_MAX)) begin
                ovf_out = 1'b1;
                y_out   = {`PMD_EXP_TOP, sgn, `PMD_FRAC_FULL};
            end else if ($signed(en) < $signed(`PMD_EXP_MIN)) begin
                unf_out = 1'b1;
            end else begin
                y_out = {en[7:0], sgn, fr};
            end
        end
    end
endmodule // pmd_fmul

// ### rtl/pmd_fsub.v
`timescale 1ns/1ps
`include "pmd_consts.vh"
module pmd_fsub (
    input  wire [39:0] a_in,
    input  wire [39:0] b_in,
    output reg  [39:0] y_out,
    output reg         ovf_out,
    output reg         unf_out
);
    wire [7:0]  ea  = a_in[`PMD_EXP_MSB:`PMD_EXP_LSB];
    wire [7:0]  eb  = b_in[`PMD_EXP_MSB:`PMD_EXP_LSB];
    wire        sa  = a_in[`PMD_SGN_BIT];
    wire        sb  = ~b_in[`PMD_SGN_BIT];
    wire        za  = (ea == `PMD_EXP_ZERO);
    wire        zb  = (eb == `PMD_EXP_ZERO);
    wire [31:0] ma  = {1'b1, a_in[`PMD_FRAC_MSB:0]};
    wire [31:0] mb  = {1'b1, b_in[`PMD_FRAC_MSB:0]};
    wire        big = ($signed(ea) > $signed(eb)) || ((ea == eb) && (ma >= mb));
    wire [7:0]  eh  = big ? ea : eb;
    wire [7:0]  el  = big ? eb : ea;
    wire [31:0] mh  = big ? ma : mb;
    wire [31:0] ml  = big ? mb : ma;
    wire        sh  = big ? sa : sb;
    wire        sl  = big ? sb : sa;
    wire [8:0]  dif = {eh[7], eh} - {el[7], el};
    wire [31:0] mls = (dif >= `PMD_ALIGN_LIMIT) ? 32'h00000000 : (ml >> dif);
    wire [32:0] sum = (sh == sl) ? ({1'b0, mh} + {1'b0, mls}) : ({1'b0, mh} - {1'b0, mls});
    reg  [5:0]  lz;
    reg  [31:0] nrm;
    reg  [9:0]  en;
    reg  [30:0] fr;
    integer     k;

    always @* begin
        lz = 6'h00;
        for (k = 0; k < 32; k = k + 1) begin
            if (sum[k])
                lz = 6'h1f - k[5:0];
        end
        nrm     = sum[31:0] << lz;
        en      = {{2{eh[7]}}, eh} - {4'h0, lz};
        fr      = nrm[30:0];
        ovf_out = 1'b0;
        unf_out = 1'b0;
        y_out   = {`PMD_EXP_ZERO, 32'h00000000};
        if (sum[32]) begin
            en = {{2{eh[7]}}, eh} + `PMD_EXP_ONE;
            fr = sum[31:1];
        end
        if (za && zb) begin
            y_out = {`PMD_EXP_ZERO, 32'h00000000};
        end else if (zb) begin
            y_out = a_in;
        end else if (za) begin
            y_out = {eb, sb, b_in[`PMD_FRAC_MSB:0]};
        end else if (sum != 33'h000000000) begin
            if ($signed(en) > $signed(`PMD_EXP_MAX)) begin
                ovf_out = 1'b1;
                y_out   = {`PMD_EXP_TOP, sh, `PMD_FRAC_FULL};
            end else if ($signed(en) < $signed(`PMD_EXP_MIN)) begin
                unf_out = 1'b1;
            end else begin
                y_out = {en[7:0], sh, fr};
            end
        end
    end
endmodule // pmd_fsub

// ### verification/pmd_checker.sv
`timescale 1ns/1ps
module pmd_checker (
    input wire        clk_in,
    input wire        sys_rst_in,
    input wire        op_valid_in,
    input wire [1:0]  op_kind_in,
    input wire [4:0]  dst_reg_in,
    input wire        status_wr_in,
    input wire [23:0] store_addr_in,
    input wire [6:0]  status_out,
    input wire        done_out,
    input wire        store_valid_out,
    input wire [23:0] store_addr_out,
    input wire        ext_wb_valid_out,
    input wire [4:0]  ext_wb_idx_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire k0 = op_valid_in && op_kind_in == 2'h0;
    wire k1 = op_valid_in && op_kind_in == 2'h1;
    wire k2i = op_valid_in && op_kind_in == 2'h2 && dst_reg_in < 5'h08;
    wire k2x = op_valid_in && op_kind_in == 2'h2 && dst_reg_in > 5'h07;
    // a status write may legally move every bit, so it masks the flag checks
    wire hold = !status_wr_in;
    done_pulse_a: assert property (op_valid_in |=> done_out) else $error("done missing");
    done_idle_a: assert property (!op_valid_in |=> !done_out) else $error("stray done");
    store_issue_a: assert property (k0 |=> store_valid_out && store_addr_out == $past(store_addr_in))
        else $error("store not issued");
    store_only_a: assert property (!k0 |=> !store_valid_out) else $error("stray store");
    ext_nochg_a: assert property (k2x && hold |=> $stable(status_out) && ext_wb_valid_out
        && ext_wb_idx_out == $past(dst_reg_in)) else $error("external write wrong");
    carry_keep_a: assert property (hold |=> status_out[0] == $past(status_out[0]))
        else $error("carry moved");
    sticky_keep_a: assert property (hold |=> (status_out[6:5] & $past(status_out[6:5])) == $past(status_out[6:5]))
        else $error("sticky bit cleared");
    fp_sticky_a: assert property ((k0 || k1) && hold |=> (!status_out[4] || status_out[6])
        && (!status_out[1] || status_out[5])) else $error("float sticky missing");
    sub_nz_a: assert property (k1 && hold |=> status_out[3:2] == 2'h0) else $error("pair sign flags set");
    int_flag_a: assert property (k2i && hold |=> !status_out[4] && (!status_out[1] || status_out[5])
        && status_out[6] == $past(status_out[6])) else $error("integer flags wrong");
    cover property (k1);
    cover property (k2x);
    cover property (k0 ##1 k2i);
    cover property (status_out[6:5] == 2'h3);
endmodule // pmd_checker

bind pmd_exec pmd_checker u_chk (.clk_in, .sys_rst_in, .op_valid_in, .op_kind_in, .dst_reg_in,
    .status_wr_in, .store_addr_in, .status_out, .done_out, .store_valid_out, .store_addr_out,
    .ext_wb_valid_out, .ext_wb_idx_out);

// ### verification/pmd_mem_model.sv
`timescale 1ns/1ps
module pmd_mem_model (
    input  wire        clk_in,
    input  wire        store_valid_in,
    input  wire [23:0] store_addr_in,
    input  wire [31:0] store_data_in,
    input  wire [23:0] rd_addr_in,
    output wire [31:0] rd_data_out
);
    logic [31:0] mem_q [16];
    // operands are fetched ahead of the execute edge, the store lands after it
    assign rd_data_out = mem_q[rd_addr_in[3:0]];
    initial begin
        for (int i = 0; i < 16; i++) mem_q[i] = {20'h0, i[3:0], 8'h00};
    end
    always @(posedge clk_in) begin
        if (store_valid_in) mem_q[store_addr_in[3:0]] <= store_data_in;
    end
endmodule // pmd_mem_model

// ### verification/parallel_multiply_datapath_tb_top.sv
`timescale 1ns/1ps
module parallel_multiply_datapath_tb_top;
    typedef struct packed {
        logic [1:0] k, p, a; logic [4:0] s; logic [2:0] t; logic [4:0] d; logic [31:0] m3, m4;
        logic sat; logic [2:0] rd; logic [39:0] reg_e; logic [6:0] st_e; logic [31:0] aux_e;
    } pmd_row_t;
    logic        clk_in = 0, sys_rst_in = 1, op_valid_in = 0, dst1_sel_in = 0, dst2_sel_in = 0;
    logic        saturation_mode_in = 0, status_wr_in = 0;
    logic [1:0]  op_kind_in = '0, par_mode_in = '0, addr_mode_in = '0;
    logic [2:0]  src1_reg_in = '0, src2_reg_in = '0, rd_idx_in = '0;
    logic [4:0]  src_reg_in = '0, dst_reg_in = '0;
    logic [31:0] mem3_data_in = '0, mem4_data_in = '0, ext_src_data_in = '0, ext_dst_data_in = '0;
    logic [23:0] store_addr_in = '0, mem_addr = 24'h000005;
    logic [15:0] imm_in = '0;
    logic [6:0]  status_wr_data_in = '0;
    wire  [39:0] rd_data_out;
    wire  [6:0]  status_out;
    wire         done_out, store_valid_out, ext_wb_valid_out;
    wire  [23:0] store_addr_out;
    wire  [31:0] store_data_out, ext_wb_data_out, mem_word;
    wire  [4:0]  ext_wb_idx_out;
    int          fail_count = 0, checked = 0;
    // kind-1 rows always hand over two memory words and two registers
    pmd_row_t rows [19] = '{
    '{2'h0,2'h0,2'h0,5'h00,3'h1,5'h01,32'h00004000,32'h0,1'b0,3'h1,40'h0000400000,7'h00,32'h0},
    '{2'h2,2'h0,2'h3,5'h00,3'h0,5'h01,32'h0000ff00,32'h0,1'b0,3'h1,40'h00c0000000,7'h08,32'h0},
    '{2'h0,2'h0,2'h0,5'h00,3'h1,5'h01,32'h00004000,32'h0,1'b0,3'h1,40'h0000400000,7'h00,32'h00c00000},
    '{2'h2,2'h0,2'h3,5'h00,3'h0,5'h01,32'h00001000,32'h0,1'b0,3'h1,40'h0000000000,7'h26,32'h0},
    '{2'h0,2'h0,2'h0,5'h00,3'h1,5'h01,32'h00004000,32'h0,1'b0,3'h1,40'h0000400000,7'h20,32'h0},
    '{2'h2,2'h0,2'h3,5'h00,3'h0,5'h01,32'h0000f000,32'h0,1'b1,3'h1,40'h0080000000,7'h2a,32'h0},
    '{2'h0,2'h0,2'h0,5'h00,3'h1,5'h01,32'h01000000,32'h0,1'b0,3'h1,40'h0100000000,7'h20,32'h00800000},
    '{2'h0,2'h0,2'h0,5'h00,3'h3,5'h03,32'hff000000,32'h0,1'b0,3'h3,40'hff00000000,7'h20,32'h0},
    '{2'h0,2'h0,2'h0,5'h01,3'h1,5'h02,32'h7f000000,32'h0,1'b1,3'h2,40'h7f7fffffff,7'h22,32'h01000000},
    '{2'h0,2'h0,2'h0,5'h03,3'h4,5'h04,32'h81000000,32'h0,1'b0,3'h4,40'h8000000000,7'h74,32'h0},
    '{2'h1,2'h1,2'h0,5'h03,3'h0,5'h02,32'h02000000,32'h01400000,1'b0,3'h0,40'h0100000000,7'h60,32'h0},
    '{2'h3,2'h0,2'h0,5'h00,3'h0,5'h00,32'h0,32'h0,1'b0,3'h3,40'h0100000000,7'h60,32'h0},
    '{2'h1,2'h2,2'h0,5'h01,3'h1,5'h01,32'h0,32'h0,1'b0,3'h1,40'h0200000000,7'h60,32'h0},
    '{2'h1,2'h0,2'h0,5'h01,3'h3,5'h00,32'h01000000,32'h01000000,1'b0,3'h0,40'h0200000000,7'h60,32'h0},
    '{2'h1,2'h3,2'h0,5'h03,3'h3,5'h01,32'hff000000,32'h0,1'b0,3'h1,40'h0000000000,7'h60,32'h0},
    '{2'h2,2'h0,2'h0,5'h08,3'h0,5'h09,32'h00000003,32'hfffffffe,1'b0,3'h1,40'h0,7'h60,32'hfffffffa},
    '{2'h2,2'h0,2'h1,5'h00,3'h0,5'h0a,32'h00001000,32'h00000010,1'b0,3'h1,40'h0,7'h60,32'h00010000},
    '{2'h2,2'h0,2'h2,5'h00,3'h0,5'h0b,32'h00800000,32'hab000002,1'b0,3'h1,40'h0,7'h60,32'hff000000},
    '{2'h2,2'h0,2'h3,5'h00,3'h0,5'h1f,32'h0000ffff,32'h00000005,1'b0,3'h1,40'h0,7'h60,32'hfffffffb}};

    pmd_exec DUT (.clk_in, .sys_rst_in, .op_valid_in, .op_kind_in, .par_mode_in, .addr_mode_in,
        .src1_reg_in, .src2_reg_in, .src_reg_in, .dst_reg_in, .dst1_sel_in, .dst2_sel_in,
        .mem3_data_in, .mem4_data_in, .store_addr_in, .imm_in, .ext_src_data_in, .ext_dst_data_in,
        .saturation_mode_in, .status_wr_in, .status_wr_data_in, .rd_idx_in, .rd_data_out, .status_out,
        .done_out, .store_valid_out, .store_addr_out, .store_data_out, .ext_wb_valid_out,
        .ext_wb_idx_out, .ext_wb_data_out);
    pmd_mem_model u_mem (.clk_in, .store_valid_in(store_valid_out), .store_addr_in(store_addr_out),
        .store_data_in(store_data_out), .rd_addr_in(mem_addr), .rd_data_out(mem_word));

    always #5 clk_in = ~clk_in;

    task chk(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task end_sim;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // called just after a clock edge; the op is taken at the next one
    task issue(input pmd_row_t r);
        op_valid_in <= 1'b1;
        op_kind_in <= r.k;
        par_mode_in <= r.p;
        addr_mode_in <= r.a;
        src_reg_in <= r.s;
        src1_reg_in <= r.s[2:0];
        src2_reg_in <= r.t;
        dst_reg_in <= r.d;
        dst1_sel_in <= r.d[0];
        dst2_sel_in <= r.d[1];
        mem3_data_in <= r.m3;
        mem4_data_in <= r.m4;
        imm_in <= r.m3[15:0];
        ext_src_data_in <= r.m3;
        ext_dst_data_in <= r.m4;
        saturation_mode_in <= r.sat;
        store_addr_in <= r.m4[23:0];
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk(40'(status_out), 40'h0);
        chk(rd_data_out, 40'h0);
        for (int i = 0; i < 19; i++) begin
            @(posedge clk_in);
            issue(rows[i]);
            @(posedge clk_in);
            op_valid_in <= 1'b0;
            rd_idx_in <= rows[i].rd;
            #1;
            chk(40'(done_out), 40'h1);
            chk(40'(status_out), 40'(rows[i].st_e));
            chk(40'(store_valid_out), 40'(rows[i].k == 2'h0));
            if (rows[i].k == 2'h0) chk(40'(store_data_out), 40'(rows[i].aux_e));
            if (rows[i].k == 2'h2 && rows[i].d > 5'h07) chk(40'(ext_wb_data_out), 40'(rows[i].aux_e));
            @(posedge clk_in);
            #1;
            chk(rd_data_out, rows[i].reg_e);
            $display("row %0d done", i);
        end
        @(posedge clk_in);
        status_wr_in <= 1'b1;
        status_wr_data_in <= 7'h01;
        @(posedge clk_in);
        status_wr_in <= 1'b0;
        issue('{2'h0,2'h0,2'h0,5'h01,3'h0,5'h05,32'h00004000,32'h0,1'b0,3'h5,40'h0,7'h0,32'h0});
        @(posedge clk_in);
        issue('{2'h2,2'h0,2'h3,5'h00,3'h0,5'h05,32'h0000ff00,32'h0,1'b0,3'h5,40'h0,7'h0,32'h0});
        rd_idx_in <= 3'h5;
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        #1;
        chk(40'(status_out), 40'h09);
        chk(40'(done_out), 40'h1);
        chk(rd_data_out, 40'h0000400000);
        @(posedge clk_in);
        #1;
        chk(rd_data_out, 40'h00c0000000);
        $display("back to back done");
        @(posedge clk_in);
        issue('{2'h0,2'h0,2'h0,5'h01,3'h5,5'h06,mem_word,32'h5,1'b0,3'h6,40'h0,7'h0,32'h0});
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        rd_idx_in <= 3'h6;
        #1;
        chk(40'(store_data_out), 40'h00c00000);
        @(posedge clk_in);
        #1;
        chk(rd_data_out, 40'h0000050000);
        chk(40'(mem_word), 40'h00c00000);
        $display("shared word done");
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd_idx_in <= 3'h5;
        @(posedge clk_in);
        #1;
        chk(40'(status_out), 40'h0);
        chk(rd_data_out, 40'h0);
        $display("reset done");
        end_sim;
    end

    // the whole sequence needs under 100 cycles; twenty times that is a hang
    initial begin
        #20000;
        fail_count++;
        end_sim;
    end
endmodule // parallel_multiply_datapath_tb_top
